//--- tic_cfg.svh
// Purpose : constants of the touch command slave
// Assumes : included by its bare name
// Notes   : definitions only
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH
// ==========================================================
// bus identity and command codes
`define TIC_I2C_ADDR   7'h38
`define TIC_CMD_STATUS 8'h02
`define TIC_CMD_XY     8'h03
`define TIC_CMD_MODE   8'hA4
`define TIC_CMD_FW     8'hA6
`define TIC_CMD_PANEL  8'hA8
`define TIC_CMD_RSVD   8'hD0
`define TIC_CMD_CFG_WR 8'hD1
`define TIC_CMD_CFG_RD 8'hD2
`define TIC_EVT_ONLY   8'h80
`define TIC_EVT_BIT    7
`define TIC_IDLE_BYTE  8'hFF
// ==========================================================
// configuration values and reset values
`define TIC_SCREEN_SELF 8'h00
`define TIC_SCREEN_MUT  8'h01
`define TIC_DIM_MIN     8'h03
`define TIC_DIM_MAX     8'h0A
`define TIC_DIM_DEF     8'h07
`define TIC_RANGE_MAX   10'h200
`define TIC_RANGE_DEF   10'h186
`define TIC_EE_BLANK    8'h00
`define TIC_EE_DONE     8'hAA
`define TIC_MODE_POLL   8'h00
`define TIC_MODE_TRIG   8'h01
`define TIC_CTRL_DEF    8'h00
// ==========================================================
// register indices, also the byte order of the config commands
`define TIC_REG_SCREEN 4'h0
`define TIC_REG_COLS   4'h1
`define TIC_REG_ROWS   4'h2
`define TIC_REG_XR_HI  4'h3
`define TIC_REG_XR_LO  4'h4
`define TIC_REG_YR_HI  4'h5
`define TIC_REG_YR_LO  4'h6
`define TIC_REG_CTRL   4'h7
`define TIC_REG_EE     4'h8
`define TIC_REG_MODE   4'h9
`define TIC_REG_STAT   4'hA
// ==========================================================
// timing
`define TIC_CLK_NS   10
`define TIC_PULSE_NS 50000
`define TIC_RATE_HZ  100
`endif

//--- tic_pkg.sv
// Purpose : types of the touch command slave
// Assumes : nothing
// Notes   : constants live in tic_cfg.svh
package tic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } tic_state_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] x;
    logic [15:0] y;
  } tic_touch_t;
  typedef struct packed {
    logic [7:0] screen;
    logic [7:0] cols;
    logic [7:0] rows;
    logic [9:0] xrange;
    logic [9:0] yrange;
    logic [7:0] ctrl;
    logic [7:0] ee;
  } tic_cfg_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tic_reg_req_t;
endpackage : tic_pkg

//--- tic_touch_slave.sv
// Purpose : command interpreter behind the two-wire slave port of a touch controller
// Assumes : scl/sda from pins, touch data and register port on mclk_i
// Notes   : sda is open drain, sda_oe_o high pulls the line low
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tic_cfg.svh"

module tic_touch_slave
  import tic_pkg::*;
#(
  parameter logic [7:0] FW_VERSION = 8'h5A, // arbitrary value
  parameter logic [7:0] PANEL_ID   = 8'hC3, // arbitrary value
  parameter int         PULSE_CYC  = `TIC_PULSE_NS / `TIC_CLK_NS,
  parameter int         PERIOD_CYC = 1000000000 / (`TIC_RATE_HZ * `TIC_CLK_NS)
)(
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_o,
  output logic              int_n_o,
  input  wire tic_touch_t   touch_i,
  input  wire tic_reg_req_t reg_req_i,
  output logic [7:0]        reg_rdata_o
);
  localparam int CNT_W = $clog2(PERIOD_CYC + 1);

  // ==========================================================
  // functions
  function automatic logic [7:0] cfg_byte(input tic_cfg_t c, input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      `TIC_REG_SCREEN: b = c.screen;
      `TIC_REG_COLS:   b = c.cols;
      `TIC_REG_ROWS:   b = c.rows;
      `TIC_REG_XR_HI:  b = {6'h00, c.xrange[9:8]};
      `TIC_REG_XR_LO:  b = c.xrange[7:0];
      `TIC_REG_YR_HI:  b = {6'h00, c.yrange[9:8]};
      `TIC_REG_YR_LO:  b = c.yrange[7:0];
      `TIC_REG_CTRL:   b = c.ctrl;
      `TIC_REG_EE:     b = c.ee;
      default:         b = 8'h00;
    endcase
    return b;
  endfunction : cfg_byte

  function automatic logic dim_ok(input logic [7:0] v);
    return (v >= `TIC_DIM_MIN) && (v <= `TIC_DIM_MAX);
  endfunction : dim_ok

  // ==========================================================
  // pin synchronisers and bus conditions
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
    end
    else
    begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ==========================================================
  // byte engine
  tic_state_t state_q;
  tic_cfg_t   cfg_q;
  logic [7:0] mode_q, cmd_q, sh_q, tx_q;
  logic [2:0] bit_q;
  logic [3:0] wr_idx_q, rd_idx_q;
  logic       addr_ph_q, rd_dir_q, ack_q, pos_second_q, xy_read_q, sda_oe_q, got8_q;
  logic [7:0] rx_byte;
  logic       rx_done, addr_match, ld_tx;
  assign rx_byte    = {sh_q[6:0], sda_s_q};
  assign rx_done    = (state_q == ST_RX) && scl_rise && (bit_q == 3'h7);
  assign addr_match = (rx_byte[7:1] == `TIC_I2C_ADDR);
  assign ld_tx      = scl_fall && (((state_q == ST_RX_ACK) && addr_ph_q && rd_dir_q)
                                || ((state_q == ST_TX_ACK) && ack_q));

  logic [7:0] resp;
  always_comb
  begin
    resp = `TIC_IDLE_BYTE;
    unique case (cmd_q)
      `TIC_CMD_STATUS: resp = {7'h00, touch_i.valid};
      `TIC_CMD_XY:
        if (pos_second_q)
          resp = `TIC_EVT_ONLY;
        else
          unique case (rd_idx_q)
            4'h0:    resp = {1'b1, touch_i.x[14:8]};
            4'h1:    resp = touch_i.x[7:0];
            4'h2:    resp = touch_i.y[15:8];
            4'h3:    resp = touch_i.y[7:0];
            default: resp = `TIC_IDLE_BYTE;
          endcase
      `TIC_CMD_FW:     resp = FW_VERSION;
      `TIC_CMD_PANEL:  resp = PANEL_ID;
      `TIC_CMD_CFG_RD: resp = cfg_byte(cfg_q, rd_idx_q);
      default:         resp = `TIC_IDLE_BYTE;
    endcase
  end

  // the device only ever answers; it never drives scl or a start
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      state_q   <= ST_IDLE;
      bit_q     <= 3'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      sda_oe_q  <= 1'b0;
      addr_ph_q <= 1'b0;
      rd_dir_q  <= 1'b0;
      ack_q     <= 1'b0;
      got8_q    <= 1'b0;
    end
    else if (bus_start)
    begin
      state_q   <= ST_RX;
      bit_q     <= 3'h0;
      got8_q    <= 1'b0;
      addr_ph_q <= 1'b1;
      sda_oe_q  <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
      unique case (state_q)
        ST_IDLE: sda_oe_q <= 1'b0;
        ST_RX:
        begin
          if (scl_rise)
          begin
            sh_q   <= rx_byte;
            bit_q  <= bit_q + 3'h1;
            got8_q <= rx_done;
            if (rx_done && addr_ph_q)
              rd_dir_q <= rx_byte[0];
            if (rx_done && addr_ph_q && !addr_match)
              state_q <= ST_IDLE;
          end
          // only a fall after the eighth bit opens the ack slot, not the start's fall
          else if (scl_fall && got8_q)
          begin
            got8_q   <= 1'b0;
            state_q  <= ST_RX_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        ST_RX_ACK:
          if (scl_fall)
          begin
            addr_ph_q <= 1'b0;
            if (ld_tx)
            begin
              tx_q     <= resp;
              sda_oe_q <= ~resp[7];
              state_q  <= ST_TX;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_RX;
            end
          end
        ST_TX:
          if (scl_fall)
          begin
            bit_q <= bit_q + 3'h1;
            tx_q  <= {tx_q[6:0], 1'b0};
            if (bit_q == 3'h7)
            begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_TX_ACK;
            end
            else
              sda_oe_q <= ~tx_q[6];
          end
        ST_TX_ACK:
          if (scl_rise)
            ack_q <= ~sda_s_q;
          else if (scl_fall)
          begin
            if (ld_tx)
            begin
              tx_q     <= resp;
              sda_oe_q <= ~resp[7];
              state_q  <= ST_TX;
            end
            else
              state_q <= ST_IDLE;
          end
      endcase
  end

  // ==========================================================
  // command tracking
  logic       wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] stage_q;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cmd_q        <= 8'h00;
      wr_idx_q     <= 4'h0;
      rd_idx_q     <= 4'h0;
      pos_second_q <= 1'b0;
      xy_read_q    <= 1'b0;
    end
    else
    begin
      if (rx_done && !addr_ph_q)
      begin
        if (wr_idx_q == 4'h0)
        begin
          cmd_q    <= rx_byte;
          rd_idx_q <= 4'h0;
        end
        wr_idx_q <= wr_idx_q + 4'h1;
      end
      if (bus_start || bus_stop)
      begin
        wr_idx_q  <= 4'h0;
        xy_read_q <= 1'b0;
        if (xy_read_q)
          pos_second_q <= ~pos_second_q;
      end
      if (ld_tx)
      begin
        rd_idx_q  <= rd_idx_q + 4'h1;
        xy_read_q <= (cmd_q == `TIC_CMD_XY);
      end
    end
  end

  // host config bytes win over a same-cycle register write
  always_comb
  begin
    wr_en   = 1'b0;
    wr_idx  = 4'h0;
    wr_data = rx_byte;
    if (rx_done && !addr_ph_q && wr_idx_q != 4'h0)
    begin
      wr_en  = (cmd_q == `TIC_CMD_CFG_WR) || (cmd_q == `TIC_CMD_MODE);
      wr_idx = (cmd_q == `TIC_CMD_MODE) ? `TIC_REG_MODE : wr_idx_q - 4'h1;
    end
    else if (reg_req_i.wr)
    begin
      wr_en   = 1'b1;
      wr_idx  = reg_req_i.addr;
      wr_data = reg_req_i.wdata;
    end
  end

  // ==========================================================
  // configuration store
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q.screen <= `TIC_SCREEN_SELF;
      cfg_q.cols   <= `TIC_DIM_DEF;
      cfg_q.rows   <= `TIC_DIM_DEF;
      cfg_q.xrange <= `TIC_RANGE_DEF;
      cfg_q.yrange <= `TIC_RANGE_DEF;
      cfg_q.ctrl   <= `TIC_CTRL_DEF;
      cfg_q.ee     <= `TIC_EE_BLANK;
      mode_q       <= `TIC_MODE_POLL;
      stage_q      <= 8'h00;
    end
    else if (wr_en)
      unique case (wr_idx)
        // mutual capacitance is refused, the field keeps its value
        `TIC_REG_SCREEN: if (wr_data == `TIC_SCREEN_SELF) cfg_q.screen <= wr_data;
        `TIC_REG_COLS:   if (dim_ok(wr_data)) cfg_q.cols <= wr_data;
        `TIC_REG_ROWS:   if (dim_ok(wr_data)) cfg_q.rows <= wr_data;
        `TIC_REG_XR_HI,
        `TIC_REG_YR_HI:  stage_q <= wr_data;
        `TIC_REG_XR_LO:
          if ({stage_q, wr_data} <= {6'h00, `TIC_RANGE_MAX})
            cfg_q.xrange <= {stage_q[1:0], wr_data};
        `TIC_REG_YR_LO:
        begin
          if ({stage_q, wr_data} <= {6'h00, `TIC_RANGE_MAX})
            cfg_q.yrange <= {stage_q[1:0], wr_data};
          cfg_q.ee <= `TIC_EE_DONE;
        end
        `TIC_REG_CTRL:   if (reg_req_i.wr) cfg_q.ctrl <= wr_data;
        `TIC_REG_EE:
          if (wr_data == `TIC_EE_BLANK || wr_data == `TIC_EE_DONE)
            cfg_q.ee <= wr_data;
        `TIC_REG_MODE:
          if (wr_data == `TIC_MODE_POLL || wr_data == `TIC_MODE_TRIG)
            mode_q <= wr_data;
        default: ;
      endcase
  end

  // ==========================================================
  // touch interrupt
  logic [CNT_W-1:0] cnt_q;
  logic             touch_p_q, int_n_q;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q     <= '0;
      touch_p_q <= 1'b0;
      int_n_q   <= 1'b1;
    end
    else
    begin
      touch_p_q <= touch_i.valid;
      // the touch edge itself is cycle 0 of the period
      if (touch_i.valid && !touch_p_q)
        cnt_q <= CNT_W'(1);
      else if (cnt_q == CNT_W'(PERIOD_CYC - 1))
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;
      if (mode_q == `TIC_MODE_TRIG)
        int_n_q <= ~(touch_i.valid && (touch_p_q ? (cnt_q < CNT_W'(PULSE_CYC))
                                                  : 1'b1));
      else
        int_n_q <= ~touch_i.valid;
    end
  end

  // ==========================================================
  // register read port
  logic [7:0] rdata_q;
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      rdata_q <= 8'h00;
    else if (reg_req_i.rd)
      unique case (reg_req_i.addr)
        `TIC_REG_MODE: rdata_q <= mode_q;
        `TIC_REG_STAT: rdata_q <= {4'h0, pos_second_q, state_q};
        default:       rdata_q <= cfg_byte(cfg_q, reg_req_i.addr);
      endcase
    else
      rdata_q <= 8'h00;
  end

  assign sda_o       = 1'b0 & sda_oe_q;
  assign sda_oe_o    = sda_oe_q;
  assign int_n_o     = int_n_q;
  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // checks
  sequence s_trig_touch;
    (mode_q == `TIC_MODE_TRIG) && touch_i.valid && !touch_p_q;
  endsequence
  sequence s_held_low;
    !int_n_o [*8];
  endsequence

  a_addr_nack: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rx_done && addr_ph_q && !addr_match |=> !sda_oe_o [*2])
    else $error("foreign address acknowledged");
  a_slave_only: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    sda_oe_o |-> (state_q != ST_IDLE))
    else $error("sda driven outside a transfer");
  a_poll_level: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (mode_q == `TIC_MODE_POLL) && touch_i.valid |=> !int_n_o)
    else $error("interrupt not low while touched");
  a_mode_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wr_en && (wr_idx == `TIC_REG_MODE) && (wr_data == `TIC_MODE_TRIG)
      |=> (mode_q == `TIC_MODE_TRIG))
    else $error("interrupt mode not taken");
  a_status_byte: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ld_tx && (cmd_q == `TIC_CMD_STATUS) |=> (tx_q == {7'h00, $past(touch_i.valid)}))
    else $error("wrong touch status byte");
  a_second_evt: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ld_tx && (cmd_q == `TIC_CMD_XY) && pos_second_q |=> (tx_q == `TIC_EVT_ONLY))
    else $error("second position read not 0x80");
  a_dim_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    dim_ok(cfg_q.cols) && dim_ok(cfg_q.rows))
    else $error("column or row count out of range");
  a_pixel_max: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cfg_q.xrange <= `TIC_RANGE_MAX) && (cfg_q.yrange <= `TIC_RANGE_MAX))
    else $error("pixel range above maximum");
  a_ee_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (cfg_q.ee == `TIC_EE_BLANK) || (cfg_q.ee == `TIC_EE_DONE))
    else $error("eeprom status code illegal");
  a_trig_pulse: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_trig_touch ##1 touch_i.valid [*8] |-> !int_n_o && $past(!int_n_o, 7))
    else $error("trigger pulse too short");
endmodule : tic_touch_slave

//--- tic_host_model.sv
// Purpose : two-wire bus master standing on the far side of the touch slave
// Assumes : sda pulled up, released line reads high; scl stands high between frames
// Notes   : 80 ns bus period, four mclk per phase, read data sampled late in the high phase
`timescale 1ns/1ps

module tic_host_model (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // ==========================================================
  // bit level
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic clk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : clk

  // start and repeated start look the same from scl low or idle high
  // wait out the slave's delayed release of an ack before raising scl
  task automatic start();
    sda_oe_o <= 1'b0;
    clk(4);
    scl_o <= 1'b1;
    clk(4);
    sda_oe_o <= 1'b1;
    clk(4);
    scl_o <= 1'b0;
  endtask : start

  task automatic stop();
    clk(2);
    sda_oe_o <= 1'b1;
    clk(2);
    scl_o <= 1'b1;
    clk(4);
    sda_oe_o <= 1'b0;
    clk(8);
  endtask : stop

  // sampled late so the slave's synchroniser delay still fits the low phase
  task automatic xbit(input logic b, output logic r);
    clk(2);
    sda_oe_o <= ~b;
    clk(2);
    scl_o <= 1'b1;
    clk(3);
    r = sda_i;
    clk(1);
    scl_o <= 1'b0;
  endtask : xbit

  // msb first, then one ack bit; last=1 releases the line in the ack slot
  task automatic xbyte(input logic [7:0] w, input logic last, output logic [7:0] r,
                       output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(w[i], b);
      r[i] = b;
    end
    xbit(last, b);
    ack = ~b;
  endtask : xbyte

  // ==========================================================
  // transactions
  task automatic wr_txn(input logic [6:0] a, input logic [7:0] cmd,
                        input logic [7:0] d [8], input int n, output logic ack);
    logic [7:0] r;
    logic       k;
    start();
    xbyte({a, 1'b0}, 1'b1, r, ack);
    if (ack)
    begin
      xbyte(cmd, 1'b1, r, k);
      for (int i = 0; i < n; i++) xbyte(d[i], 1'b1, r, k);
    end
    stop();
  endtask : wr_txn

  // write address and command, restart, read n bytes, nack the last, stop
  task automatic rd_txn(input logic [6:0] a, input logic [7:0] cmd, input int n,
                        output logic [7:0] d [9], output logic ack);
    logic k;
    logic [7:0] r;
    start();
    xbyte({a, 1'b0}, 1'b1, r, ack);
    if (ack)
    begin
      xbyte(cmd, 1'b1, r, k);
      start();
      xbyte({a, 1'b1}, 1'b1, r, k);
      for (int i = 0; i < n; i++) xbyte(8'hFF, (i == n - 1), d[i], k);
    end
    stop();
  endtask : rd_txn
endmodule : tic_host_model

//--- tic_touch_slave_test.sv
// Purpose : self-checking bench of the touch command slave
// Assumes : host model on the bus pins, register port and touch input driven here
// Notes   : pulse and period counts shortened to 20 and 100 cycles
`timescale 1ns/1ps
`include "tic_cfg.svh"

module tic_touch_slave_test
  import tic_pkg::*;
;
  logic         mclk;
  logic         reset_n;
  logic         scl;
  logic         h_oe;
  logic         sda_o;
  logic         sda_oe;
  logic         int_n;
  tic_touch_t   touch;
  tic_reg_req_t req;
  logic [7:0]   rdata;
  logic [7:0]   dbuf [9];
  logic [7:0]   wbuf [8];
  int           err_count;
  int           total_checks;
  int           seed;
  int           e_scr, e_cols, e_rows, e_xr, e_yr, e_ctrl, e_ee, e_mode, hi_st;
  wire          sda_w = (sda_oe ? sda_o : 1'b1) & ~h_oe;

  tic_touch_slave #(.PULSE_CYC(20), .PERIOD_CYC(100)) i_tic_touch_slave (
    .mclk_i(mclk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .int_n_o(int_n), .touch_i(touch), .reg_req_i(req),
    .reg_rdata_o(rdata));
  tic_host_model i_tic_host_model (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl),
    .sda_oe_o(h_oe));

  // ==========================================================
  // checking and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // reference model of the configuration fields
  task automatic set_defaults();
    e_scr = 0; e_cols = 7; e_rows = 7; e_xr = 390; e_yr = 390;
    e_ctrl = 0; e_ee = 0; e_mode = 0; hi_st = 0;
  endtask : set_defaults

  task automatic reg_apply(input int a, input int v);
    case (a)
      0: if (v == 0) e_scr = v;
      1: if (v >= 3 && v <= 10) e_cols = v;
      2: if (v >= 3 && v <= 10) e_rows = v;
      3, 5: hi_st = v;
      4: if (hi_st * 256 + v <= 512) e_xr = hi_st * 256 + v;
      6: if (hi_st * 256 + v <= 512) e_yr = hi_st * 256 + v;
      7: e_ctrl = v;
      8: if (v == 0 || v == 8'hAA) e_ee = v;
      9: if (v <= 1) e_mode = v;
      default: ;
    endcase
  endtask : reg_apply

  function automatic logic [7:0] exp_reg(input int a);
    case (a)
      0: return 8'(e_scr);
      1: return 8'(e_cols);
      2: return 8'(e_rows);
      3: return 8'(e_xr >> 8);
      4: return 8'(e_xr);
      5: return 8'(e_yr >> 8);
      6: return 8'(e_yr);
      7: return 8'(e_ctrl);
      8: return 8'(e_ee);
      default: return 8'(e_mode);
    endcase
  endfunction : exp_reg

  // ==========================================================
  // register port and bus wrappers
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
    reg_apply(a, v);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd

  task automatic chk_regs();
    logic [7:0] v;
    for (int a = 0; a < 10; a++)
    begin
      reg_rd(4'(a), v);
      chk_byte(v, exp_reg(a));
    end
  endtask : chk_regs

  task automatic bus_rd(input logic [7:0] cmd, input int n);
    logic ack;
    i_tic_host_model.rd_txn(`TIC_I2C_ADDR, cmd, n, dbuf, ack);
    chk_byte({7'h00, ack}, 8'h01);
    chk_byte({7'h00, sda_oe}, 8'h00);
  endtask : bus_rd

  task automatic bus_wr(input logic [7:0] cmd, input int n);
    logic ack;
    i_tic_host_model.wr_txn(`TIC_I2C_ADDR, cmd, wbuf, n, ack);
    chk_byte({7'h00, ack}, 8'h01);
  endtask : bus_wr

  // ==========================================================
  // stimulus
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #500000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    logic [7:0] v;
    logic       ack;
    int         cnt;
    logic [7:0] cmds [3];
    logic [7:0] exps [3];
    seed = 26; err_count = 0; total_checks = 0;
    reset_n = 1'b0; touch = '0; req = '0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    set_defaults();
    chk_regs();
    reg_rd(4'hF, v);
    chk_byte(v, 8'h00);
    @(posedge mclk);
    #1 chk_byte(rdata, 8'h00);
    for (int t = 0; t < 2; t++)
    begin
      @(posedge mclk);
      touch <= '{valid: t[0], x: 16'($random(seed) & 511), y: 16'($random(seed) & 511)};
      repeat (3) @(posedge mclk);
      bus_rd(`TIC_CMD_STATUS, 1);
      chk_byte(dbuf[0], 8'(t));
    end
    for (int r = 0; r < 2; r++)
    begin
      bus_rd(`TIC_CMD_XY, 4);
      chk_byte(dbuf[0], {1'b1, touch.x[14:8]});
      chk_byte(dbuf[1], touch.x[7:0]);
      chk_byte(dbuf[2], touch.y[15:8]);
      chk_byte(dbuf[3], touch.y[7:0]);
      bus_rd(`TIC_CMD_XY, 1);
      chk_byte(dbuf[0], `TIC_EVT_ONLY);
    end
    i_tic_host_model.rd_txn(7'h39, `TIC_CMD_STATUS, 1, dbuf, ack);
    chk_byte({7'h00, ack}, 8'h00);
    cmds = '{`TIC_CMD_FW, `TIC_CMD_PANEL, `TIC_CMD_RSVD};
    exps = '{8'h5A, 8'hC3, `TIC_IDLE_BYTE};
    for (int i = 0; i < 3; i++)
    begin
      bus_rd(cmds[i], 1);
      chk_byte(dbuf[0], exps[i]);
    end
    e_xr = 512;
    e_yr = ($random(seed) & 511) + 1;
    e_cols = 4; e_rows = 9; e_ee = 8'hAA;
    wbuf = '{8'h00, 8'h04, 8'h09, 8'(e_xr >> 8), 8'(e_xr), 8'(e_yr >> 8), 8'(e_yr), 8'h00};
    bus_wr(`TIC_CMD_CFG_WR, 7);
    chk_regs();
    bus_rd(`TIC_CMD_CFG_RD, 9);
    for (int i = 0; i < 9; i++) chk_byte(dbuf[i], exp_reg(i));
    reg_wr(4'h0, 8'h01);
    reg_wr(4'h3, 8'h02);
    reg_wr(4'h4, 8'h01);
    reg_wr(4'h9, 8'h02);
    reg_wr(4'h8, 8'h55);
    for (int i = 0; i < 8; i++) reg_wr(4'(1 + (i & 1)), 8'($random(seed) & 15));
    chk_regs();
    wbuf[0] = `TIC_MODE_TRIG;
    bus_wr(`TIC_CMD_MODE, 1);
    e_mode = 1;
    chk_regs();
    @(posedge mclk);
    touch.valid <= 1'b0;
    repeat (150) @(posedge mclk);
    touch.valid <= 1'b1;
    cnt = 0;
    repeat (300)
    begin
      @(posedge mclk);
      if (int_n === 1'b0) cnt++;
    end
    chk_cnt(cnt, 60);
    reg_wr(4'h9, `TIC_MODE_POLL);
    touch.valid <= 1'b0;
    repeat (5) @(posedge mclk);
    chk_byte({7'h00, int_n}, 8'h01);
    touch.valid <= 1'b1;
    repeat (5) @(posedge mclk);
    chk_byte({7'h00, int_n}, 8'h00);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    set_defaults();
    chk_regs();
    print_verdict();
  end
endmodule : tic_touch_slave_test
